// >>> verilog/transport_host_regs.svh
// Constants for the transport selector builder, checker and SDU feeder.
`ifndef TRANSPORT_HOST_REGS_SVH
`define TRANSPORT_HOST_REGS_SVH

// Selector parameter codes and fixed length octet.
`define SEL_CODE_CALLING   8'hc1
`define SEL_CODE_CALLED    8'hc2
`define SEL_LEN_VALUE      8'h05

// Octets in one selector, and in the calling plus called pair.
`define SEL_OCTETS         4'h7
`define SEL_PAIR_OCTETS    4'he

// Octet positions inside one selector.
`define SEL_POS_CODE       3'h0
`define SEL_POS_LEN        3'h1
`define SEL_POS_APP        3'h2
`define SEL_POS_KIND       3'h3
`define SEL_POS_ID_HI      3'h4
`define SEL_POS_ID_MID     3'h5
`define SEL_POS_ID_LO      3'h6

// Application type field split and class prefixes.
`define APP_MAIN_MSB       7
`define APP_MAIN_LSB       3
`define APP_MAIN_TRAIN     5'h02
`define APP_MAIN_NAT_TRACK 5'h03
`define APP_MAIN_KEY       5'h04
`define APP_AUTO_PREFIX    7'h18
`define APP_NAT_NONINTEROP 8'h17
`define APP_ERROR_VALUE    8'hff

// Entity kind codes.
`define KIND_RADIO_BLOCK   8'h01
`define KIND_ENGINE        8'h02
`define KIND_FIELD_ELEMENT 8'h04
`define KIND_UNKNOWN       8'hff
`define ID_UNKNOWN         24'hffffff

// Service data unit lengths in octets.
`define SDU_RECOMMENDED    8'd123
`define TPDU_MAX_OCTETS    8'd128

`endif

// >>> verilog/transport_host_pkg.sv
// Types shared by the transport service user controller.
package transport_host_pkg;

    // Class of an application type octet.
    typedef enum logic [2:0] {
        APP_OTHER          = 3'b000,
        APP_TRAIN_PROT     = 3'b001,
        APP_NAT_TRACK      = 3'b010,
        APP_KEY_MGMT       = 3'b011,
        APP_AUTO_OP        = 3'b100,
        APP_NAT_NONINTEROP = 3'b101,
        APP_ERROR          = 3'b110
    } app_class_t;

    // First fault seen in a received selector pair.
    typedef enum logic [2:0] {
        RX_OK         = 3'b000,
        RX_BAD_CODE   = 3'b001,
        RX_BAD_LEN    = 3'b010,
        RX_APP_DIFFER = 3'b011,
        RX_APP_ERROR  = 3'b100,
        RX_BAD_KIND   = 3'b101,
        RX_BAD_SIZE   = 3'b110
    } rx_err_t;

    // Selector transmit sequencer states.
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;

endpackage

// >>> verilog/transport_user_host.sv
// Transport service user controller: selector builder, selector checker and SDU feeder.
`include "transport_host_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module transport_user_host (
    input  wire logic                        I_MCLK,         // System clock, 25 MHz.
    input  wire logic                        I_NRST,         // Asynchronous reset, active low.
    input  wire logic                        I_CONN_REQ,     // Start a selector pair, pulse.
    input  wire logic [7:0]                  I_APP_TYPE,     // Requested application type.
    input  wire logic [7:0]                  I_CALLING_KIND, // Calling entity kind.
    input  wire logic [23:0]                 I_CALLING_ID,   // Calling entity identifier.
    input  wire logic [7:0]                  I_CALLED_KIND,  // Called or responding kind.
    input  wire logic [23:0]                 I_CALLED_ID,    // Called or responding id.
    output logic                             O_REQ_BUSY,     // Sequencer busy, request ignored.
    output logic                             O_REQ_REFUSED,  // Request refused, pulse.
    output logic                             O_SEL_VALID,    // Selector octet valid.
    output logic [7:0]                       O_SEL_DATA,     // Selector octet.
    output logic                             O_SEL_LAST,     // Last selector octet.
    input  wire logic                        I_SEL_READY,    // Device takes selector octet.
    input  wire logic                        I_RX_VALID,     // Received selector octet valid.
    input  wire logic [7:0]                  I_RX_DATA,      // Received selector octet.
    input  wire logic                        I_RX_LAST,      // Last received selector octet.
    output logic                             O_RX_DONE,      // Check result valid, pulse.
    output logic                             O_RX_OK,        // Pair well formed.
    output transport_host_pkg::rx_err_t      O_RX_ERR,       // First fault found.
    output transport_host_pkg::app_class_t   O_RX_CLASS,     // Class of received type.
    input  wire logic                        I_SDU_VALID,    // User SDU octet valid.
    input  wire logic [7:0]                  I_SDU_DATA,     // User SDU octet.
    input  wire logic                        I_SDU_LAST,     // Last octet of user SDU.
    output logic                             O_SDU_READY,    // Feeder takes user octet.
    output logic                             O_TX_VALID,     // SDU octet to device valid.
    output logic [7:0]                       O_TX_DATA,      // SDU octet to device.
    output logic                             O_TX_LAST,      // Last SDU octet to device.
    input  wire logic                        I_TX_READY,     // Device takes SDU octet.
    output logic                             O_SDU_LONG      // Current SDU exceeds advice.
);
    import transport_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared functions.

    // Classify an application type octet by its documented ranges.
    function automatic app_class_t app_class(input logic [7:0] app);
        if (app == `APP_ERROR_VALUE) return APP_ERROR;
        if (app == `APP_NAT_NONINTEROP) return APP_NAT_NONINTEROP;
        if (app[`APP_MAIN_MSB:`APP_MAIN_LSB] == `APP_MAIN_TRAIN) return APP_TRAIN_PROT;
        if (app[`APP_MAIN_MSB:`APP_MAIN_LSB] == `APP_MAIN_NAT_TRACK) return APP_NAT_TRACK;
        if (app[`APP_MAIN_MSB:`APP_MAIN_LSB] == `APP_MAIN_KEY) return APP_KEY_MGMT;
        if (app[7:1] == `APP_AUTO_PREFIX) return APP_AUTO_OP;
        return APP_OTHER;
    endfunction

    // Unknown kind is legal only beside the unknown identifier.
    function automatic logic kind_ok(input logic [7:0] kind, input logic [23:0] id);
        return (kind != `KIND_UNKNOWN) || (id == `ID_UNKNOWN);
    endfunction

    // Octet at a position within one selector.
    function automatic logic [7:0] sel_octet(input logic [2:0] pos, input logic [7:0] code,
                                             input logic [7:0] app, input logic [7:0] kind,
                                             input logic [23:0] id);
        unique case (pos)
            `SEL_POS_CODE:   return code;
            `SEL_POS_LEN:    return `SEL_LEN_VALUE;
            `SEL_POS_APP:    return app;
            `SEL_POS_KIND:   return kind;
            `SEL_POS_ID_HI:  return id[23:16];
            `SEL_POS_ID_MID: return id[15:8];
            `SEL_POS_ID_LO:  return id[7:0];
            default:         return 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Selector transmit sequencer.

    tx_state_t   tx_state_q, tx_state_d;
    logic [3:0]  tx_idx_q, tx_idx_d;
    logic [71:0] req_q, req_d; // App type, calling kind and id, called kind and id.
    logic [7:0]  sel_data_q, sel_data_d;
    logic        refused_q, refused_d;
    logic        req_ok;
    logic [7:0]  next_octet;
    logic [3:0]  next_idx;

    // Both selectors share one application type, so a mismatch cannot be sent.
    assign req_ok = (app_class(I_APP_TYPE) != APP_ERROR)
                    && kind_ok(I_CALLING_KIND, I_CALLING_ID)
                    && kind_ok(I_CALLED_KIND, I_CALLED_ID);

    // Calling selector first, then called or responding selector.
    always_comb begin
        next_idx   = tx_idx_q + 4'h1;
        next_octet = (next_idx < `SEL_OCTETS)
            ? sel_octet(next_idx[2:0], `SEL_CODE_CALLING, req_q[71:64], req_q[63:56],
                        req_q[55:32])
            : sel_octet(3'(next_idx - `SEL_OCTETS), `SEL_CODE_CALLED, req_q[71:64],
                        req_q[31:24], req_q[23:0]);
        tx_state_d = tx_state_q;
        tx_idx_d   = tx_idx_q;
        req_d      = req_q;
        sel_data_d = sel_data_q;
        refused_d  = 1'b0;
        unique case (tx_state_q)
            TX_IDLE: begin
                if (I_CONN_REQ && req_ok) begin
                    tx_state_d = TX_SEND;
                    tx_idx_d   = 4'h0;
                    req_d      = {I_APP_TYPE, I_CALLING_KIND, I_CALLING_ID,
                                  I_CALLED_KIND, I_CALLED_ID};
                    sel_data_d = `SEL_CODE_CALLING;
                end else if (I_CONN_REQ) begin
                    refused_d = 1'b1;
                end
            end
            TX_SEND: begin
                if (I_SEL_READY) begin
                    if (tx_idx_q == `SEL_PAIR_OCTETS - 4'h1) begin
                        tx_state_d = TX_IDLE;
                    end else begin
                        tx_idx_d   = next_idx;
                        sel_data_d = next_octet;
                    end
                end
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_state_q <= TX_IDLE;
            tx_idx_q   <= 4'h0;
            req_q      <= 72'h0;
            sel_data_q <= 8'h00;
            refused_q  <= 1'b0;
        end else begin
            tx_state_q <= tx_state_d;
            tx_idx_q   <= tx_idx_d;
            req_q      <= req_d;
            sel_data_q <= sel_data_d;
            refused_q  <= refused_d;
        end
    end

    assign O_REQ_BUSY    = (tx_state_q == TX_SEND);
    assign O_REQ_REFUSED = refused_q;
    assign O_SEL_VALID   = (tx_state_q == TX_SEND);
    assign O_SEL_DATA    = sel_data_q;
    assign O_SEL_LAST    = (tx_state_q == TX_SEND) && (tx_idx_q == `SEL_PAIR_OCTETS - 4'h1);

    ////////////////////////////////////////////////////////////////////////////////
    // Received selector pair checker.

    logic [3:0]  rx_idx_q, rx_idx_d;
    rx_err_t     rx_err_q, rx_err_d, err_now;
    logic [7:0]  rx_app_q, rx_app_d;
    logic        rx_kunk_q, rx_kunk_d;
    logic        rx_idones_q, rx_idones_d;
    logic        done_q, done_d, ok_q, ok_d;
    rx_err_t     res_err_q, res_err_d;
    app_class_t  res_cls_q, res_cls_d;
    logic [2:0]  rx_pos;
    logic        rx_second;

    // Each octet is judged by its place; only the first fault is kept.
    always_comb begin
        rx_second   = (rx_idx_q >= `SEL_OCTETS);
        rx_pos      = rx_second ? 3'(rx_idx_q - `SEL_OCTETS) : rx_idx_q[2:0];
        err_now     = RX_OK;
        rx_idx_d    = rx_idx_q;
        rx_err_d    = rx_err_q;
        rx_app_d    = rx_app_q;
        rx_kunk_d   = rx_kunk_q;
        rx_idones_d = rx_idones_q;
        done_d      = 1'b0;
        ok_d        = ok_q;
        res_err_d   = res_err_q;
        res_cls_d   = res_cls_q;
        if (I_RX_VALID) begin
            if (rx_idx_q >= `SEL_PAIR_OCTETS) begin
                err_now = RX_BAD_SIZE;
            end else begin
                unique case (rx_pos)
                    `SEL_POS_CODE: begin
                        if (I_RX_DATA != (rx_second ? `SEL_CODE_CALLED : `SEL_CODE_CALLING))
                            err_now = RX_BAD_CODE;
                    end
                    `SEL_POS_LEN: if (I_RX_DATA != `SEL_LEN_VALUE) err_now = RX_BAD_LEN;
                    `SEL_POS_APP: begin
                        if (app_class(I_RX_DATA) == APP_ERROR)
                            err_now = RX_APP_ERROR;
                        else if (rx_second && (I_RX_DATA != rx_app_q))
                            err_now = RX_APP_DIFFER;
                        if (!rx_second)
                            rx_app_d = I_RX_DATA;
                    end
                    `SEL_POS_KIND: begin
                        rx_kunk_d   = (I_RX_DATA == `KIND_UNKNOWN);
                        rx_idones_d = 1'b1;
                    end
                    `SEL_POS_ID_LO: begin
                        if (rx_kunk_q && !(rx_idones_q && (I_RX_DATA == 8'hff)))
                            err_now = RX_BAD_KIND;
                    end
                    default: begin
                        rx_idones_d = rx_idones_q && (I_RX_DATA == 8'hff);
                    end
                endcase
                rx_idx_d = rx_idx_q + 4'h1;
            end
            if ((rx_err_q == RX_OK) && (err_now != RX_OK))
                rx_err_d = err_now;
            if (I_RX_LAST) begin
                done_d    = 1'b1;
                res_err_d = (rx_err_d == RX_OK) && (rx_idx_d != `SEL_PAIR_OCTETS)
                            ? RX_BAD_SIZE : rx_err_d;
                ok_d      = (res_err_d == RX_OK);
                res_cls_d = app_class(rx_app_d);
                rx_idx_d  = 4'h0;
                rx_err_d  = RX_OK;
            end
        end
    end

    // Register the checker state and its result.
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_idx_q    <= 4'h0;
            rx_err_q    <= RX_OK;
            rx_app_q    <= 8'h00;
            rx_kunk_q   <= 1'b0;
            rx_idones_q <= 1'b0;
            done_q      <= 1'b0;
            ok_q        <= 1'b0;
            res_err_q   <= RX_OK;
            res_cls_q   <= APP_OTHER;
        end else begin
            rx_idx_q    <= rx_idx_d;
            rx_err_q    <= rx_err_d;
            rx_app_q    <= rx_app_d;
            rx_kunk_q   <= rx_kunk_d;
            rx_idones_q <= rx_idones_d;
            done_q      <= done_d;
            ok_q        <= ok_d;
            res_err_q   <= res_err_d;
            res_cls_q   <= res_cls_d;
        end
    end

    assign O_RX_DONE  = done_q;
    assign O_RX_OK    = ok_q;
    assign O_RX_ERR   = res_err_q;
    assign O_RX_CLASS = res_cls_q;

    ////////////////////////////////////////////////////////////////////////////////
    // SDU feeder: one register stage toward the device, with a length watch.

    logic       txv_q, txv_d, txl_q, txl_d, long_q, long_d, first_q, first_d;
    logic [7:0] txd_q, txd_d, cnt_q, cnt_d;
    logic       take;

    // Long SDUs still pass; the device segments them, the flag only warns.
    always_comb begin
        take    = I_SDU_VALID && O_SDU_READY;
        txv_d   = txv_q;
        txd_d   = txd_q;
        txl_d   = txl_q;
        cnt_d   = cnt_q;
        long_d  = long_q;
        first_d = first_q;
        if (txv_q && I_TX_READY)
            txv_d = 1'b0;
        if (take) begin
            txv_d   = 1'b1;
            txd_d   = I_SDU_DATA;
            txl_d   = I_SDU_LAST;
            cnt_d   = first_q ? 8'h01 : ((cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01);
            long_d  = (cnt_d > `SDU_RECOMMENDED) || (!first_q && long_q);
            first_d = I_SDU_LAST;
        end
    end

    // Register the feeder stage.
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            txv_q   <= 1'b0;
            txd_q   <= 8'h00;
            txl_q   <= 1'b0;
            cnt_q   <= 8'h00;
            long_q  <= 1'b0;
            first_q <= 1'b1;
        end else begin
            txv_q   <= txv_d;
            txd_q   <= txd_d;
            txl_q   <= txl_d;
            cnt_q   <= cnt_d;
            long_q  <= long_d;
            first_q <= first_d;
        end
    end

    assign O_SDU_READY = !txv_q || I_TX_READY;
    assign O_TX_VALID  = txv_q;
    assign O_TX_DATA   = txd_q;
    assign O_TX_LAST   = txl_q;
    assign O_SDU_LONG  = long_q;

endmodule // transport_user_host

`default_nettype wire

// >>> tb/transport_user_host_properties.sv
// Port checks for the transport user controller.
`timescale 1ns/1ps
`default_nettype none
module transport_user_host_checker
    import transport_host_pkg::*;
(
    input wire logic       I_MCLK,        // Clock.
    input wire logic       I_NRST,        // Reset, active low.
    input wire logic       I_CONN_REQ,    // Request.
    input wire logic       O_REQ_BUSY,    // Busy.
    input wire logic       O_REQ_REFUSED, // Refusal pulse.
    input wire logic       O_SEL_VALID,   // Octet offered.
    input wire logic [7:0] O_SEL_DATA,    // Octet.
    input wire logic       O_SEL_LAST,    // Last octet.
    input wire logic       I_SEL_READY,   // Taken.
    input wire logic       I_RX_VALID,    // Rx octet.
    input wire logic       I_RX_LAST,     // Rx last.
    input wire logic       O_RX_DONE,     // Result pulse.
    input wire logic       O_RX_OK,       // Pair good.
    input wire rx_err_t    O_RX_ERR,      // Fault.
    input wire logic       I_SDU_VALID,   // User octet.
    input wire logic [7:0] I_SDU_DATA,    // User data.
    input wire logic       O_SDU_READY,   // Feeder ready.
    input wire logic       O_TX_VALID,    // Octet out.
    input wire logic [7:0] O_TX_DATA,     // Data out.
    input wire logic       O_TX_LAST,     // Last out.
    input wire logic       I_TX_READY     // Device ready.
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Every idle request is answered next cycle, by a selector or a refusal, never both.
    a_req_answer: assert property (I_CONN_REQ && !O_REQ_BUSY |=> O_SEL_VALID != O_REQ_REFUSED)
        else $error("request not answered once");
    a_first_code: assert property ($rose(O_SEL_VALID) |-> O_SEL_DATA == 8'hc1 && O_REQ_BUSY)
        else $error("pair does not open with calling code");
    a_len_octet: assert property ($rose(O_SEL_VALID) && I_SEL_READY |=> O_SEL_DATA == 8'h05)
        else $error("length octet wrong");
    // A stalled octet must not move, or the device would lose it.
    a_sel_hold: assert property (O_SEL_VALID && !I_SEL_READY |=> O_SEL_VALID && $stable(O_SEL_DATA))
        else $error("selector octet moved while stalled");
    a_pair_end: assert property (O_SEL_VALID && I_SEL_READY && O_SEL_LAST |=> !O_SEL_VALID && !O_REQ_BUSY)
        else $error("pair did not end after last octet");
    a_refuse_pulse: assert property (O_REQ_REFUSED |=> !O_REQ_REFUSED && !O_SEL_VALID)
        else $error("refusal not a lone pulse");
    a_rx_done: assert property (I_RX_VALID && I_RX_LAST |=> O_RX_DONE)
        else $error("no result after last octet");
    a_ok_match: assert property (O_RX_DONE |-> O_RX_OK == (O_RX_ERR == RX_OK))
        else $error("ok flag disagrees with fault code");
    a_tx_pass: assert property (I_SDU_VALID && O_SDU_READY |=> O_TX_VALID && O_TX_DATA == $past(I_SDU_DATA))
        else $error("user octet not passed on");
    a_tx_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable({O_TX_DATA, O_TX_LAST}))
        else $error("octet to device moved while stalled");
endmodule // transport_user_host_checker
bind transport_user_host transport_user_host_checker u_chk (.I_MCLK, .I_NRST, .I_CONN_REQ,
    .O_REQ_BUSY, .O_REQ_REFUSED, .O_SEL_VALID, .O_SEL_DATA, .O_SEL_LAST, .I_SEL_READY, .I_RX_VALID,
    .I_RX_LAST, .O_RX_DONE, .O_RX_OK, .O_RX_ERR, .I_SDU_VALID, .I_SDU_DATA, .O_SDU_READY,
    .O_TX_VALID, .O_TX_DATA, .O_TX_LAST, .I_TX_READY);
`default_nettype wire

// >>> tb/device_partner.sv
// Behavioural transport entity taking selector and user octets.
`timescale 1ns/1ps
`default_nettype none
module device_partner (
    input  wire logic       i_clk,       // Clock.
    input  wire logic       i_rst_n,     // Reset, active low.
    input  wire logic       i_slow,      // Stall every other cycle.
    input  wire logic       i_sel_valid, // Selector octet.
    input  wire logic [7:0] i_sel_data,  // Selector data.
    input  wire logic       i_sel_last,  // Last of pair.
    output logic            o_sel_ready, // Selector taken.
    input  wire logic       i_tx_valid,  // User octet.
    input  wire logic [7:0] i_tx_data,   // User data.
    input  wire logic       i_tx_last,   // End of unit.
    output logic            o_tx_ready   // User octet taken.
);
    logic [7:0] sel_mem [14];
    logic [3:0] sel_n;
    logic [7:0] seg_len, last_len, last_dat, seg_cnt;
    logic       rdy;
    assign o_sel_ready = rdy;
    assign o_tx_ready  = rdy;
    // Only class 2 normal data exists here; no expedited, reject or acknowledge traffic.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {rdy, sel_n, seg_len, last_len, last_dat, seg_cnt} <= '0;
        end else begin
            rdy <= i_slow ? !rdy : 1'b1;
            if (i_sel_valid && rdy) begin
                sel_mem[sel_n] <= i_sel_data;
                sel_n <= i_sel_last ? 4'h0 : sel_n + 4'h1;
            end
            // Cut 128-octet segments; the final one carries the rest and ends the unit.
            if (i_tx_valid && rdy) begin
                last_dat <= i_tx_data;
                seg_len <= (seg_len == 8'h7f || i_tx_last) ? 8'h00 : seg_len + 8'h01;
                if (seg_len == 8'h7f || i_tx_last) begin
                    seg_cnt <= seg_cnt + 8'h01;
                    last_len <= seg_len + 8'h01;
                end
            end
        end
    end
endmodule // device_partner
`default_nettype wire

// >>> tb/transport_user_host_test.sv
// Self-checking bench for the transport user controller.
`timescale 1ns/1ps
`default_nettype none
module transport_user_host_test;
    import transport_host_pkg::*;
    logic        mclk = 1'b0, nrst = 1'b0, conn_req = 1'b0, slow = 1'b0;
    logic        rx_valid = 1'b0, rx_last = 1'b0, sdu_valid = 1'b0, sdu_last = 1'b0;
    logic [7:0]  app_type = '0, calling_kind = '0, called_kind = '0, rx_data = '0, sdu_data = '0;
    logic [23:0] calling_id = '0, called_id = '0;
    logic        req_busy, req_refused, sel_valid, sel_last, sel_ready, rx_done, rx_ok;
    logic        sdu_ready, tx_valid, tx_last, tx_ready, sdu_long;
    logic [7:0]  sel_data, tx_data;
    rx_err_t     rx_err;
    app_class_t  rx_class;
    int          error_cnt = 0, checked = 0;
    transport_user_host u_dut (.I_MCLK(mclk), .I_NRST(nrst), .I_CONN_REQ(conn_req),
        .I_APP_TYPE(app_type), .I_CALLING_KIND(calling_kind), .I_CALLING_ID(calling_id),
        .I_CALLED_KIND(called_kind), .I_CALLED_ID(called_id), .O_REQ_BUSY(req_busy),
        .O_REQ_REFUSED(req_refused), .O_SEL_VALID(sel_valid), .O_SEL_DATA(sel_data),
        .O_SEL_LAST(sel_last), .I_SEL_READY(sel_ready), .I_RX_VALID(rx_valid),
        .I_RX_DATA(rx_data), .I_RX_LAST(rx_last), .O_RX_DONE(rx_done), .O_RX_OK(rx_ok),
        .O_RX_ERR(rx_err), .O_RX_CLASS(rx_class), .I_SDU_VALID(sdu_valid), .I_SDU_DATA(sdu_data),
        .I_SDU_LAST(sdu_last), .O_SDU_READY(sdu_ready), .O_TX_VALID(tx_valid),
        .O_TX_DATA(tx_data), .O_TX_LAST(tx_last), .I_TX_READY(tx_ready), .O_SDU_LONG(sdu_long));
    device_partner u_dev (.i_clk(mclk), .i_rst_n(nrst), .i_slow(slow), .i_sel_valid(sel_valid),
        .i_sel_data(sel_data), .i_sel_last(sel_last), .o_sel_ready(sel_ready),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last), .o_tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        if (got !== exp) begin
            $display("BAD %s expected %0h seen %0h", name, exp, got);
            error_cnt++;
        end
        checked++;
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Pulses one request; the answer is visible at the following falling edge.
    task automatic request(input logic s, input logic [7:0] a, k1, k2, input logic [23:0] d1, d2);
        @(negedge mclk);
        {slow, app_type, calling_kind, called_kind, calling_id, called_id} = {s, a, k1, k2, d1, d2};
        conn_req = 1'b1;
        @(negedge mclk);
        conn_req = 1'b0;
    endtask
    task automatic t_select(input logic s, input logic [7:0] a, k1, k2, input logic [23:0] d1, d2);
        logic [7:0] e [14];
        int n;
        e = '{8'hc1, 8'h05, a, k1, d1[23:16], d1[15:8], d1[7:0],
              8'hc2, 8'h05, a, k2, d2[23:16], d2[15:8], d2[7:0]};
        request(s, a, k1, k2, d1, d2);
        chk("selector offered", 1, sel_valid);
        n = 0;
        while (req_busy === 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        for (int i = 0; i < 14; i++) chk("selector octet", e[i], u_dev.sel_mem[i]);
    endtask
    task automatic t_refuse(input logic [7:0] a, k, input logic [23:0] d);
        request(1'b0, a, k, k, d, d);
        chk("refused", 1, req_refused);
        chk("no selector", 0, sel_valid);
    endtask
    // Sends a received pair of n octets, then judges the check result.
    task automatic rx_case(input logic [7:0] a1, a2, k, input logic [23:0] d,
                           input logic [2:0] err, cls, input int n = 14,
                           input logic [7:0] c = 8'hc1, l = 8'h05);
        logic [7:0] rb [14];
        rb = '{c, l, a1, k, d[23:16], d[15:8], d[7:0], 8'hc2, 8'h05, a2, k, d[23:16], d[15:8], d[7:0]};
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            {rx_valid, rx_data, rx_last} = {1'b1, rb[i], i == n - 1};
        end
        @(negedge mclk);
        {rx_valid, rx_last} = 2'b00;
        chk("rx done", 1, rx_done);
        chk("rx fault", err, rx_err);
        chk("rx class", cls, rx_class);
        chk("rx ok", err == 3'h0, rx_ok);
    endtask
    task automatic t_rx_classes();
        rx_case(8'h10, 8'h10, 8'h02, 24'h000123, 3'h0, 3'h1);
        rx_case(8'h1a, 8'h1a, 8'h01, 24'h000456, 3'h0, 3'h2);
        rx_case(8'h1b, 8'h1b, 8'h04, 24'h000789, 3'h0, 3'h2);
        rx_case(8'h20, 8'h20, 8'h01, 24'h00abcd, 3'h0, 3'h3);
        rx_case(8'h21, 8'h21, 8'h01, 24'h00abcd, 3'h0, 3'h3);
        rx_case(8'h30, 8'h30, 8'h02, 24'h000001, 3'h0, 3'h4);
        rx_case(8'h31, 8'h31, 8'hff, 24'hffffff, 3'h0, 3'h4);
        rx_case(8'h17, 8'h17, 8'h02, 24'h000002, 3'h0, 3'h5);
        rx_case(8'hff, 8'hff, 8'h02, 24'h000123, 3'h4, 3'h6);
        rx_case(8'h10, 8'h11, 8'h02, 24'h000123, 3'h3, 3'h1);
        rx_case(8'h10, 8'h10, 8'h02, 24'h000123, 3'h1, 3'h1, 14, 8'hc3);
        rx_case(8'h10, 8'h10, 8'h02, 24'h000123, 3'h2, 3'h1, 14, 8'hc1, 8'h06);
        rx_case(8'h10, 8'h10, 8'hff, 24'h000123, 3'h5, 3'h1);
        rx_case(8'h10, 8'h10, 8'h02, 24'h000123, 3'h6, 3'h1, 13);
    endtask
    // Feeds one unit of n octets, holding each one while the feeder is not ready.
    task automatic t_sdu(input logic s, input int n, input logic [7:0] segs, lastlen, input logic lng);
        logic [7:0] s0;
        int w;
        @(negedge mclk);
        slow = s;
        s0 = u_dev.seg_cnt;
        for (int i = 0; i < n; i++) begin
            if (i > 0) @(negedge mclk);
            {sdu_valid, sdu_data, sdu_last} = {1'b1, 8'(i), i == n - 1};
            w = 0;
            while (sdu_ready !== 1'b1 && w < 10) begin
                @(negedge mclk);
                w++;
            end
        end
        @(negedge mclk);
        {sdu_valid, sdu_last} = 2'b00;
        w = 0;
        while (tx_valid === 1'b1 && w < 10) begin
            @(negedge mclk);
            w++;
        end
        chk("segments", segs, u_dev.seg_cnt - s0);
        chk("last segment length", lastlen, u_dev.last_len);
        chk("last octet", 8'(n - 1), u_dev.last_dat);
        chk("long flag", lng, sdu_long);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    // Free-running 25 MHz clock.
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Ends a hang; the run needs well under two thousand cycles.
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        t_select(1'b0, 8'h1a, 8'h01, 8'h02, 24'h123456, 24'h9abcde);
        t_select(1'b1, 8'h30, 8'h04, 8'hff, 24'h00abcd, 24'hffffff);
        t_refuse(8'hff, 8'h01, 24'h000001);
        t_refuse(8'h10, 8'hff, 24'h000001);
        t_rx_classes();
        t_sdu(1'b1, 300, 8'h03, 8'h2c, 1'b1);
        t_sdu(1'b0, 123, 8'h01, 8'h7b, 1'b0);
        t_sdu(1'b1, 128, 8'h01, 8'h80, 1'b1);
        t_sdu(1'b0, 1, 8'h01, 8'h01, 1'b0);
        report_and_stop();
    end
endmodule // transport_user_host_test
`default_nettype wire
